// ==== design/bfr_core.sv ====
// Notes on behaviour
// - Initial burst latency is programmable from two to seven clock cycles.
// - A burst reaching a 64-word boundary stalls one cycle with ready low.
// - Address latches on first active edge with strobe low, or strobe rise.
// - Linear mode walks up inside the 8-word group and wraps until restarted.
// - Ready-timing bit one puts ready in the same cycle as its data.
// - Ready-timing bit zero puts ready one cycle ahead of its data.
// - Clock-edge bit picks falling edge at zero, rising edge at one.
// - Reduced handshaking shortens first access for even start addresses.
// - Reduced handshaking works only in clocked burst, flagged by ready.
// - Asynchronous access time counts from later of address or strobe fall.
// - Data lines are driven only while output enable and select are low.
`timescale 1ns/1ps
module bfr_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bfr_pkg::bfr_pins_t pins,
  output logic [bfr_pkg::DATA_W-1:0] word_data_lines_o,
  output logic word_data_lines_oe,
  output logic ready_o
);
  import bfr_pkg::*;

  // Pin synchronisers; logic reads stage two, and the edge detectors also read stage three.
  bfr_pins_t pin_m;
  bfr_pins_t pin_s;
  bfr_pins_t pin_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m <= '1;
      pin_s <= '1;
      pin_d <= '1;
    end else begin
      pin_m <= pins;
      pin_s <= pin_m;
      pin_d <= pin_s;
    end
  end
  logic clk_rise;
  logic clk_fall;
  logic act_edge;
  logic avs_rise;
  logic avs_fall;
  assign clk_rise = pin_s.flash_clk & ~pin_d.flash_clk;
  assign clk_fall = ~pin_s.flash_clk & pin_d.flash_clk;
  assign avs_rise = pin_s.address_valid_strobe_n
                    & ~pin_d.address_valid_strobe_n;
  assign avs_fall = ~pin_s.address_valid_strobe_n
                    & pin_d.address_valid_strobe_n;
  // APB register file.
  bfr_cfg_t cfg;
  bfr_cfg_t next_cfg;
  logic [MEM_AW-1:0] mem_index;
  logic [MEM_AW-1:0] next_mem_index;
  logic mem_we;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] next_prdata;
  logic next_pslverr;
  bfr_state_t state;
  logic [ADDR_W-1:0] burst_addr;
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_CTRL) || (a == OFS_STATUS)
                || (a == OFS_MEM_INDEX) || (a == OFS_MEM_DATA);
  endfunction : is_mapped
  // Every transfer completes in its first access cycle.
  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~penable & ~pwrite;
  assign mem_we = apb_wr & (paddr == OFS_MEM_DATA);
  assign act_edge = cfg.clock_edge_select_bit ? clk_rise : clk_fall;
  always_comb begin
    next_cfg = cfg;
    next_mem_index = mem_index;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (apb_wr && paddr == OFS_CTRL) begin
      next_cfg.wait_states = pwdata[CTRL_WS_LSB +: 3];
      // Out-of-range wait states are clamped to the supported span.
      if (pwdata[CTRL_WS_LSB +: 3] < WS_MIN) begin
        next_cfg.wait_states = WS_MIN;
      end
      next_cfg.clock_edge_select_bit = pwdata[CTRL_EDGE_BIT];
      next_cfg.ready_timing_select_bit = pwdata[CTRL_RDYT_BIT];
      next_cfg.reduced = pwdata[CTRL_REDUCED_BIT];
      next_cfg.sync_mode = pwdata[CTRL_SYNC_BIT];
      next_cfg.linear8 = pwdata[CTRL_LIN8_BIT];
    end
    if (apb_wr && paddr == OFS_MEM_INDEX) begin
      next_mem_index = pwdata[MEM_AW-1:0];
    end
    if (mem_we) begin
      next_mem_index = mem_index + 1'b1;
    end
    if (psel && penable && !is_mapped(paddr)) begin
      next_pslverr = 1'b1;
    end
    if (apb_rd) begin
      case (paddr)
        OFS_CTRL: next_prdata = {24'h0, cfg};
        OFS_STATUS: next_prdata = {9'h0, burst_addr, state};
        OFS_MEM_INDEX: next_prdata = {24'h0, mem_index};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '{LIN8_RESET, SYNC_RESET, REDUCED_RESET, RDYT_RESET,
               EDGE_RESET, WS_RESET};
      mem_index <= '0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      mem_index <= next_mem_index;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end
  // Burst engine.
  logic latched;
  logic next_latched;
  bfr_state_t next_state;
  logic [ADDR_W-1:0] next_burst_addr;
  logic [ADDR_W-1:0] step_addr;
  logic [2:0] wcnt;
  logic [2:0] next_wcnt;
  logic [2:0] lat_q;
  logic [2:0] next_lat_q;
  logic latch_ev;
  logic boundary;
  assign latch_ev = cfg.sync_mode & ~latched
    & ((~pin_s.address_valid_strobe_n & act_edge) | avs_rise);
  assign step_addr = cfg.linear8
    ? {burst_addr[ADDR_W-1:GROUP_BITS],
       burst_addr[GROUP_BITS-1:0] + 3'h1}
    : burst_addr + 21'h1;
  assign boundary = (step_addr[BOUNDARY_BITS-1:0] == '0);

  always_comb begin
    next_state = state;
    next_burst_addr = burst_addr;
    next_wcnt = wcnt;
    next_lat_q = lat_q;
    next_latched = latched;
    if (avs_fall) begin
      next_latched = 1'b0;
    end
    if (latch_ev) begin
      next_latched = 1'b1;
      next_burst_addr = pin_s.word_address_lines;
      next_lat_q = cfg.wait_states;
      // Even start in reduced mode saves one cycle of latency.
      if (cfg.reduced && !pin_s.word_address_lines[0]) begin
        next_lat_q = cfg.wait_states - 3'h1;
      end
      next_wcnt = next_lat_q - 3'h1;
      next_state = ST_WAIT;
    end else if (act_edge) begin
      case (state)
        ST_WAIT: begin
          if (wcnt == 3'h0) begin
            next_state = ST_DATA;
          end else begin
            next_wcnt = wcnt - 3'h1;
          end
        end
        ST_DATA: begin
          next_burst_addr = step_addr;
          next_state = boundary ? ST_STALL : ST_DATA;
        end
        ST_STALL: next_state = ST_DATA;
        default: next_state = ST_IDLE;
      endcase
    end
    if (!cfg.sync_mode) begin
      next_state = ST_IDLE;
    end
    // The hardware reset pin ends any burst.
    if (!pin_s.hw_reset_n) begin
      next_state = ST_IDLE;
      next_latched = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      burst_addr <= '0;
      wcnt <= 3'h0;
      lat_q <= WS_RESET;
      latched <= 1'b0;
    end else begin
      state <= next_state;
      burst_addr <= next_burst_addr;
      wcnt <= next_wcnt;
      lat_q <= next_lat_q;
      latched <= next_latched;
    end
  end
  // Asynchronous access.
  logic [ADDR_W-1:0] async_addr;
  logic [ADDR_W-1:0] next_async_addr;
  logic [4:0] acc_cnt;
  logic [4:0] next_acc_cnt;
  logic acc_done;
  logic addr_moved;
  assign addr_moved = ~pin_s.address_valid_strobe_n
                      & (pin_s.word_address_lines != async_addr);
  assign acc_done = (acc_cnt == 5'h0);

  always_comb begin
    next_async_addr = async_addr;
    next_acc_cnt = acc_cnt;
    if (!pin_s.address_valid_strobe_n) begin
      next_async_addr = pin_s.word_address_lines;
    end
    // Either event restarts the count, so the later one sets the time.
    if (avs_fall || addr_moved) begin
      next_acc_cnt = ASYNC_ACC_CYC;
    end else if (!acc_done) begin
      next_acc_cnt = acc_cnt - 5'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_addr <= '0;
      acc_cnt <= 5'h0;
    end else begin
      async_addr <= next_async_addr;
      acc_cnt <= next_acc_cnt;
    end
  end
  // Array and output stage.
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_dout;
  logic next_oe;
  logic ready_same;
  logic ready_early;
  bfr_mem u_mem (
    .pclk(pclk),
    .we(mem_we),
    .waddr(mem_index),
    .wdata(pwdata[DATA_W-1:0]),
    .raddr(cfg.sync_mode ? burst_addr[MEM_AW-1:0]
                         : async_addr[MEM_AW-1:0]),
    .rdata(rdata)
  );
  assign ready_same = (state == ST_DATA);
  assign ready_early = (state == ST_WAIT && wcnt == 3'h0)
                       || (state == ST_DATA && !boundary)
                       || (state == ST_STALL);
  assign ready_o = !cfg.sync_mode ? acc_done
                 : cfg.ready_timing_select_bit ? ready_same
                 : ready_early;

  always_comb begin
    next_dout = word_data_lines_o;
    if (cfg.sync_mode ? ready_same : acc_done) begin
      next_dout = rdata;
    end
    next_oe = ~pin_s.select_n & ~pin_s.output_enable_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_data_lines_o <= '0;
      word_data_lines_oe <= 1'b0;
    end else begin
      word_data_lines_o <= next_dout;
      word_data_lines_oe <= next_oe;
    end
  end
  // Helper count of active edges spent waiting.
  logic [3:0] edge_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt <= 4'h0;
    end else if (latch_ev) begin
      edge_cnt <= 4'h0;
    end else if (act_edge && state == ST_WAIT) begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_data_edge;
    state == ST_DATA && act_edge && !latch_ev && pin_s.hw_reset_n
    && cfg.sync_mode;
  endsequence

  a_wait_latency: assert property (
    $rose(state == ST_DATA) && $past(state) == ST_WAIT
    |-> edge_cnt == {1'b0, lat_q})
    else $error("first word not after programmed wait states");
  a_boundary_stall: assert property (
    s_data_edge ##0 boundary |=> state == ST_STALL && !ready_same)
    else $error("no stall at 64-word boundary");
  a_addr_capture: assert property (
    latch_ev && pin_s.hw_reset_n
    |=> burst_addr == $past(pin_s.word_address_lines))
    else $error("address not captured on strobe or edge");
  a_wrap_order: assert property (
    s_data_edge ##0 cfg.linear8 |=>
    burst_addr[GROUP_BITS-1:0] == $past(burst_addr[GROUP_BITS-1:0]) + 3'h1
    && burst_addr[ADDR_W-1:GROUP_BITS]
       == $past(burst_addr[ADDR_W-1:GROUP_BITS]))
    else $error("linear burst out of order");
  a_ready_same: assert property (
    cfg.sync_mode && cfg.ready_timing_select_bit && $rose(ready_o)
    |-> state == ST_DATA)
    else $error("ready not aligned with data");
  a_ready_early: assert property (
    cfg.sync_mode && !cfg.ready_timing_select_bit && state == ST_WAIT
    && wcnt == 3'h0 |-> ready_o)
    else $error("ready not one cycle ahead");
  a_reduced_even: assert property (
    latch_ev && pin_s.hw_reset_n && cfg.reduced
    && !pin_s.word_address_lines[0]
    |=> lat_q == $past(cfg.wait_states) - 3'h1)
    else $error("even start not shortened");
  a_async_time: assert property (
    !cfg.sync_mode && avs_fall |=> !acc_done [*8])
    else $error("async access finished too early");
  a_drive_gate: assert property (
    word_data_lines_oe |-> $past(!pin_s.select_n && !pin_s.output_enable_n))
    else $error("data driven without enable and select");
endmodule : bfr_core

// ==== design/bfr_pkg.sv ====
package bfr_pkg;
  // APB register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MEM_INDEX = 8'h08;
  localparam logic [7:0] OFS_MEM_DATA = 8'h0c;
  // Control field positions.
  localparam int CTRL_WS_LSB = 0;
  localparam int CTRL_EDGE_BIT = 3;
  localparam int CTRL_RDYT_BIT = 4;
  localparam int CTRL_REDUCED_BIT = 5;
  localparam int CTRL_SYNC_BIT = 6;
  localparam int CTRL_LIN8_BIT = 7;
  // Reset values and wait-state limits.
  localparam logic [2:0] WS_RESET = 3'h7;
  localparam logic [2:0] WS_MIN = 3'h2;
  localparam logic [2:0] WS_MAX = 3'h7;
  localparam logic EDGE_RESET = 1'b1;
  localparam logic RDYT_RESET = 1'b1;
  localparam logic REDUCED_RESET = 1'b0;
  localparam logic SYNC_RESET = 1'b1;
  localparam logic LIN8_RESET = 1'b1;
  // Widths and sizes.
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int MEM_AW = 8;
  localparam int BOUNDARY_BITS = 6;
  localparam int GROUP_BITS = 3;
  // Asynchronous access time.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ASYNC_ACC_NS = 70;
  localparam logic [4:0] ASYNC_ACC_CYC =
    5'((ASYNC_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DATA = 2'b10,
    ST_STALL = 2'b11
  } bfr_state_t;

  typedef struct packed {
    logic flash_clk;
    logic select_n;
    logic address_valid_strobe_n;
    logic output_enable_n;
    logic hw_reset_n;
    logic [ADDR_W-1:0] word_address_lines;
  } bfr_pins_t;

  typedef struct packed {
    logic linear8;
    logic sync_mode;
    logic reduced;
    logic ready_timing_select_bit;
    logic clock_edge_select_bit;
    logic [2:0] wait_states;
  } bfr_cfg_t;
endpackage : bfr_pkg

// ==== design/bfr_mem.sv ====
`timescale 1ns/1ps
module bfr_mem (
  input wire logic pclk,
  input wire logic we,
  input wire logic [bfr_pkg::MEM_AW-1:0] waddr,
  input wire logic [bfr_pkg::DATA_W-1:0] wdata,
  input wire logic [bfr_pkg::MEM_AW-1:0] raddr,
  output logic [bfr_pkg::DATA_W-1:0] rdata
);
  import bfr_pkg::*;
  // No reset, so the array maps onto plain memory cells.
  logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : bfr_mem

// ==== dv/bfr_host_model.sv ====
`timescale 1ns/1ps
module bfr_host_model (
  input wire logic pclk,
  output bfr_pkg::bfr_pins_t pins,
  input wire logic [bfr_pkg::DATA_W-1:0] word_data_lines_o,
  input wire logic ready_o
);
  import bfr_pkg::*;
  // Flash clock phase after the active edge in pclk cycles (the other lasts 15); the device needs the clock below pclk/4.
  localparam int HALF = 8;
  logic [DATA_W-1:0] words[$];
  int first_cyc;
  int last_cyc;

  initial begin
    pins = '0;
    pins.select_n = 1'b1;
    pins.address_valid_strobe_n = 1'b1;
    pins.output_enable_n = 1'b1;
    pins.hw_reset_n = 1'b1;
  end

  task automatic sel(input logic sel_n, input logic oe_n);
    @(posedge pclk);
    pins.select_n <= sel_n;
    pins.output_enable_n <= oe_n;
  endtask : sel

  task automatic hw_reset(input logic level);
    @(posedge pclk);
    pins.hw_reset_n <= level;
  endtask : hw_reset

  task automatic burst(input logic [ADDR_W-1:0] a, input logic rise,
                       input logic early, input int n);
    int cyc;
    logic prev;
    cyc = 0;
    prev = 1'b0;
    first_cyc = 0;
    words = {};
    @(posedge pclk);
    pins.flash_clk <= ~rise;
    pins.select_n <= 1'b0;
    pins.output_enable_n <= 1'b0;
    pins.word_address_lines <= a;
    pins.address_valid_strobe_n <= 1'b0;
    while (words.size() < n && cyc < 40) begin
      repeat (HALF) @(posedge pclk);
      pins.flash_clk <= rise;
      // Address is not held after latching, so it is scrambled on purpose.
      if (cyc == 1) pins.word_address_lines <= ~a;
      repeat (HALF) @(posedge pclk);
      pins.flash_clk <= ~rise;
      pins.address_valid_strobe_n <= 1'b1;
      repeat (HALF - 1) @(posedge pclk);
      @(negedge pclk);
      if (early ? prev : ready_o) begin
        words.push_back(word_data_lines_o);
        last_cyc = cyc;
      end
      if (ready_o && first_cyc == 0) first_cyc = cyc;
      prev = ready_o;
      cyc++;
    end
    @(posedge pclk);
    pins.select_n <= 1'b1;
    pins.output_enable_n <= 1'b1;
  endtask : burst

  task automatic async_read(input logic [ADDR_W-1:0] a,
                            input logic [ADDR_W-1:0] b,
                            output logic [DATA_W-1:0] d, output int waited);
    @(posedge pclk);
    pins.select_n <= 1'b0;
    pins.output_enable_n <= 1'b0;
    pins.word_address_lines <= a;
    pins.address_valid_strobe_n <= 1'b0;
    repeat (8) @(posedge pclk);
    pins.word_address_lines <= b;
    repeat (4) @(posedge pclk);
    waited = 12;
    do begin
      @(negedge pclk);
      waited++;
    end while (ready_o !== 1'b1 && waited < 80);
    // The word register loads one clock after ready rises in this mode.
    @(negedge pclk);
    d = word_data_lines_o;
    @(posedge pclk);
    pins.select_n <= 1'b1;
    pins.output_enable_n <= 1'b1;
    pins.address_valid_strobe_n <= 1'b1;
  endtask : async_read
endmodule : bfr_host_model

// ==== dv/bfr_tb.sv ====
`timescale 1ns/1ps
module testbench;
  import bfr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  bfr_pins_t pins;
  logic [DATA_W-1:0] data;
  logic oe;
  logic rdy;
  int num_errors = 0;
  int comparisons = 0;

  always #2 pclk = ~pclk;

  bfr_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .word_data_lines_o(data), .word_data_lines_oe(oe), .ready_o(rdy));
  bfr_host_model host (.pclk(pclk), .pins(pins),
    .word_data_lines_o(data), .ready_o(rdy));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] word_at(input int a);
    return 32'h1000 + 32'(a);
  endfunction : word_at

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) num_errors++;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic stop_test;
    $display("errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic test_regs;
    logic [31:0] r;
    apb(OFS_CTRL, 1'b0, 32'h0, r);
    check("ctrl reset", r, 32'h0000_00df);
    apb(8'h10, 1'b0, 32'h0, r);
    check("unmapped data", r, 32'h0);
    @(negedge pclk);
    check("unmapped error", {31'h0, pslverr}, 32'h1);
    apb(OFS_MEM_INDEX, 1'b1, 32'h0, r);
    for (int i = 0; i < 72; i++) apb(OFS_MEM_DATA, 1'b1, word_at(i), r);
  endtask : test_regs

  task automatic test_latency;
    logic [31:0] r;
    for (int ws = 2; ws <= 7; ws++) begin
      apb(OFS_CTRL, 1'b1, 32'hd8 | 32'(ws), r);
      host.burst(21'd6, 1'b1, 1'b0, 9);
      check("first ready", 32'(host.first_cyc), 32'(ws));
      for (int k = 0; k < 9; k++) begin
        check("wrap word", {16'h0, host.words[k]}, word_at((6 + k) % 8));
      end
    end
  endtask : test_latency

  task automatic test_modes;
    logic [31:0] r;
    // Falling active edge with ready one clock ahead of its word.
    apb(OFS_CTRL, 1'b1, 32'hc4, r);
    host.burst(21'd3, 1'b0, 1'b1, 4);
    check("early ready", 32'(host.first_cyc), 32'd3);
    check("falling first", {16'h0, host.words[0]}, word_at(3));
    check("falling last", {16'h0, host.words[3]}, word_at(6));
    apb(OFS_CTRL, 1'b1, 32'hfd, r);
    for (int a = 4; a < 6; a++) begin
      host.burst(21'(a), 1'b1, 1'b0, 2);
      check("reduced first", 32'(host.first_cyc), 32'(a));
      check("reduced word", {16'h0, host.words[0]}, word_at(a));
    end
  endtask : test_modes

  task automatic test_boundary;
    logic [31:0] r;
    apb(OFS_CTRL, 1'b1, 32'h5a, r);
    host.burst(21'd62, 1'b1, 1'b0, 4);
    for (int k = 0; k < 4; k++) begin
      check("linear word", {16'h0, host.words[k]}, word_at(62 + k));
    end
    check("stall gap", 32'(host.last_cyc - host.first_cyc), 32'd4);
    check("ready held", {31'h0, rdy}, 32'h1);
    host.hw_reset(1'b0);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    check("reset ends burst", {31'h0, rdy}, 32'h0);
    apb(OFS_STATUS, 1'b0, 32'h0, r);
    check("status after reset", r, 32'h0000_0104);
    host.hw_reset(1'b1);
  endtask : test_boundary

  task automatic test_async;
    logic [31:0] r;
    logic [DATA_W-1:0] d;
    int w;
    apb(OFS_CTRL, 1'b1, 32'h9f, r);
    host.async_read(21'd10, 21'd20, d, w);
    check("async word", {16'h0, d}, word_at(20));
    check("async time", 32'(w >= 26 && w <= 32), 32'd1);
    for (int i = 0; i < 3; i++) begin
      host.sel(i == 2, i == 1);
      repeat (6) @(posedge pclk);
      @(negedge pclk);
      check("drive enable", {31'h0, oe}, 32'(i == 0));
    end
  endtask : test_async

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_latency();
    test_modes();
    test_boundary();
    test_async();
    stop_test();
  end

  // Far above the few thousand cycles the scenarios need.
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule : testbench
